// File: design/spi_quirk_core.v
`timescale 1ns/100ps
`default_nettype none
`include "spi_quirk_regs.vh"
module spi_quirk_core #(
   parameter DW = `DATA_BITS,
   parameter NS = `NUM_SEL
) (
   input wire sys_clk,
   input wire reset_n,
   input wire enable_cmd,
   input wire disable_cmd,
   input wire soft_reset_bit,
   input wire master_mode,
   input wire fault_detect_disable,
   input wire [1:0] select_index,
   input wire [`CFG_WIDTH*NS-1:0] select_config_register,
   input wire tx_write,
   input wire [DW-1:0] tx_data,
   input wire rx_read,
   input wire sck_in,
   input wire mosi_in,
   input wire miso_in,
   input wire select_in_n,
   input wire fault_in_n,
   output reg sck_out,
   output reg sck_oe,
   output reg mosi_out,
   output reg mosi_oe,
   output reg miso_out,
   output reg miso_oe,
   output reg [NS-1:0] select_out_n,
   output reg spi_enabled,
   output reg transmit_empty_flag,
   output reg receive_full_flag,
   output reg mode_fault_flag,
   output reg [DW-1:0] received_word_register,
   output reg busy
);
   // ------------------------------------------------------------
   // Active select configuration
   // ------------------------------------------------------------
   wire [`CFG_WIDTH-1:0] cfg;
   wire [`CFG_WIDTH-1:0] cfg0;
   assign cfg = select_config_register[select_index*`CFG_WIDTH +:
      `CFG_WIDTH];
   assign cfg0 = select_config_register[`CFG_WIDTH-1:0];
   wire clock_polarity_bit = cfg[`CFG_POL_BIT];
   wire inverted_phase_bit = cfg[`CFG_NPHA_BIT];
   wire keep_select_after_transfer = cfg[`CFG_KEEP_BIT];
   wire [7:0] serial_clock_divider = cfg[`CFG_DIV_MSB:`CFG_DIV_LSB];
   wire keep0 = cfg0[`CFG_KEEP_BIT];

   localparam ST_IDLE = 2'd0;
   localparam ST_SHIFT = 2'd1;
   localparam ST_DONE = 2'd2;

   reg [1:0] st_q;
   reg [DW-1:0] tx_hold_q;
   reg [DW-1:0] sh_q;
   reg [4:0] half_q;
   reg [7:0] last_div_q;
   reg prev_pol_q;
   reg glitch_armed_q;
   reg sck_prev_q;
   reg sel_prev_q;
   reg [4:0] sbits_q;
   wire tick;
   wire rst = !reset_n || soft_reset_bit;

   clk_divider #(.W(8)) u_div (
      .sys_clk(sys_clk),
      .reset_n(!rst),
      .run(st_q == ST_SHIFT),
      .div(serial_clock_divider),
      .tick(tick)
   );

   // ------------------------------------------------------------
   // Control and transmit holding
   // ------------------------------------------------------------
   // Start blocked by keep-asserted select 0 with fault detection on
   wire start_block = keep0 && !fault_detect_disable;
   wire can_start = spi_enabled && master_mode && !transmit_empty_flag
      && !start_block && !mode_fault_flag;
   // Extra pulse when divider-one meets another divider in pol1/pha0
   wire extra_pulse = (last_div_q == `DIV_ONE)
      && (serial_clock_divider != `DIV_ONE)
      && clock_polarity_bit && !inverted_phase_bit;
   wire sck_edge_s = !select_in_n && (sck_in != sck_prev_q);
   wire sample_s = sck_edge_s && ((sck_in ^ clock_polarity_bit)
      == inverted_phase_bit);

   always @(posedge sys_clk) begin
      if (rst) begin
         spi_enabled <= 1'b0;
         transmit_empty_flag <= 1'b1;
         tx_hold_q <= {DW{1'b0}};
      end else begin
         if (enable_cmd) begin
            spi_enabled <= 1'b1;
         end else if (disable_cmd && master_mode) begin
            // Slave ignores disable; only soft reset or reset_n stops it
            spi_enabled <= 1'b0;
         end
         // Writes while disabled are dropped, flag untouched
         if (tx_write && spi_enabled) begin
            tx_hold_q <= tx_data;
            transmit_empty_flag <= 1'b0;
         end else if ((st_q == ST_IDLE && can_start)
            || (!master_mode && spi_enabled && sample_s
            && sbits_q == 5'd0)) begin
            // Slave reload with empty holding just resends; no underrun
            transmit_empty_flag <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Master shifter
   // ------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rst) begin
         st_q <= ST_IDLE;
         sh_q <= {DW{1'b0}};
         half_q <= 5'd0;
         sck_out <= 1'b0;
         sck_oe <= 1'b0;
         mosi_out <= 1'b0;
         mosi_oe <= 1'b0;
         select_out_n <= {NS{1'b1}};
         busy <= 1'b0;
         last_div_q <= `DIV_ZERO;
         mode_fault_flag <= 1'b0;
      end else begin
         sck_oe <= master_mode && spi_enabled;
         mosi_oe <= master_mode && spi_enabled;
         if (master_mode && spi_enabled && !fault_detect_disable
            && !fault_in_n) begin
            mode_fault_flag <= 1'b1;
         end else if (enable_cmd) begin
            mode_fault_flag <= 1'b0;
         end
         case (st_q)
            ST_IDLE: begin
               sck_out <= clock_polarity_bit;
               if (can_start) begin
                  st_q <= ST_SHIFT;
                  sh_q <= tx_hold_q;
                  mosi_out <= tx_hold_q[DW-1];
                  half_q <= 5'd0;
                  busy <= 1'b1;
                  select_out_n <= ~({{(NS-1){1'b0}}, 1'b1} << select_index);
                  if (extra_pulse) begin
                     sck_out <= !clock_polarity_bit;
                  end
               end
            end
            ST_SHIFT: begin
               if (tick) begin
                  sck_out <= !sck_out;
                  half_q <= half_q + 5'd1;
                  if (half_q[0] ^ inverted_phase_bit) begin
                     sh_q <= {sh_q[DW-2:0], miso_in};
                     mosi_out <= sh_q[DW-2];
                  end
                  if (half_q == DW*2-1) begin
                     st_q <= ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               busy <= 1'b0;
               last_div_q <= serial_clock_divider;
               sck_out <= clock_polarity_bit;
               if (!keep_select_after_transfer) begin
                  select_out_n <= {NS{1'b1}};
               end
               st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Receive side, both modes
   // ------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rst) begin
         receive_full_flag <= 1'b0;
         received_word_register <= {DW{1'b0}};
         sck_prev_q <= 1'b0;
         sel_prev_q <= 1'b1;
         prev_pol_q <= 1'b0;
         glitch_armed_q <= 1'b0;
         sbits_q <= 5'd0;
         miso_out <= 1'b0;
         miso_oe <= 1'b0;
      end else begin
         sck_prev_q <= sck_in;
         sel_prev_q <= select_in_n;
         prev_pol_q <= clock_polarity_bit;
         miso_oe <= !master_mode && spi_enabled && !select_in_n;
         if (enable_cmd && !master_mode) begin
            glitch_armed_q <= 1'b1;
         end else if (prev_pol_q != clock_polarity_bit || rx_read) begin
            glitch_armed_q <= 1'b0;
         end
         if (select_in_n) begin
            sbits_q <= 5'd0;
            miso_out <= tx_hold_q[DW-1];
         end else if (!master_mode && spi_enabled && sample_s) begin
            sbits_q <= (sbits_q == DW-1) ? 5'd0 : sbits_q + 5'd1;
         end
         // Set wins over a same-cycle read
         if (st_q == ST_DONE) begin
            received_word_register <= sh_q;
            receive_full_flag <= 1'b1;
         end else if (!master_mode && spi_enabled && sample_s
            && sbits_q == DW-1) begin
            received_word_register <= {sh_q[DW-2:0], mosi_in};
            receive_full_flag <= 1'b1;
         end else if (glitch_armed_q && !master_mode
            && (sck_edge_s || (sel_prev_q && !select_in_n))) begin
            receive_full_flag <= 1'b1;
         end else if (rx_read) begin
            receive_full_flag <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: inc/spi_quirk_regs.vh
`ifndef SPI_QUIRK_REGS_VH
`define SPI_QUIRK_REGS_VH
// Word length and chip select count
`define DATA_BITS 8
`define NUM_SEL 4
// Per-select configuration field positions
`define CFG_POL_BIT 0
`define CFG_NPHA_BIT 1
`define CFG_KEEP_BIT 2
`define CFG_DIV_LSB 8
`define CFG_DIV_MSB 15
`define CFG_WIDTH 16
// Reset values and divider constants
`define CFG_RESET 16'h0000
`define DIV_ONE 8'h01
`define DIV_ZERO 8'h00
`endif

// File: design/clk_divider.v
`timescale 1ns/100ps
`default_nettype none
module clk_divider #(
   parameter W = 8
) (
   input wire sys_clk,
   input wire reset_n,
   input wire run,
   input wire [W-1:0] div,
   output wire tick
);
   reg [W-1:0] cnt_q;
   wire [W-1:0] lim;
   // Divider of zero behaves as one so the link never stalls
   assign lim = (div == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : div;
   assign tick = run && (cnt_q == lim - {{(W-1){1'b0}}, 1'b1});
   always @(posedge sys_clk) begin
      if (!reset_n || !run || tick) begin
         cnt_q <= {W{1'b0}};
      end else begin
         cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule
`default_nettype wire

// File: test/spi_quirk_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module spi_quirk_checker #(parameter NS = 4) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic disable_cmd,
   input wire logic soft_reset_bit,
   input wire logic master_mode,
   input wire logic fault_detect_disable,
   input wire logic [16*NS-1:0] select_config_register,
   input wire logic tx_write,
   input wire logic [NS-1:0] select_out_n,
   input wire logic spi_enabled,
   input wire logic transmit_empty_flag,
   input wire logic busy
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Hang looks at select 0 alone, whichever select is addressed
   wire hang = select_config_register[2] && !fault_detect_disable;
   wire calm = !soft_reset_bit && !tx_write;
   wire off = !spi_enabled && !soft_reset_bit;
   wire slv = !master_mode && spi_enabled && calm;
   wire mst = master_mode && spi_enabled && calm;
   wire go = master_mode && spi_enabled && tx_write && !hang;
   property p_slv; slv && disable_cmd |=> spi_enabled; endproperty
   a_slv: assert property (p_slv) else $error("slave stopped");
   property p_mst; mst && disable_cmd |=> !spi_enabled; endproperty
   a_mst: assert property (p_mst) else $error("master kept on");
   property p_rst;
      soft_reset_bit |=> !spi_enabled && &select_out_n && transmit_empty_flag;
   endproperty
   a_rst: assert property (p_rst) else $error("soft reset state");
   property p_drop;
      off && tx_write |=> $stable(transmit_empty_flag);
   endproperty
   a_drop: assert property (p_drop) else $error("empty flag moved");
   property p_dflag;
      mst && !busy && disable_cmd |=> $stable(transmit_empty_flag);
   endproperty
   a_dflag: assert property (p_dflag) else $error("flag moved");
   property p_dma; off && !busy && tx_write |=> !busy; endproperty
   a_dma: assert property (p_dma) else $error("word not dropped");
   property p_hang; master_mode && hang && !busy |=> !busy; endproperty
   a_hang: assert property (p_hang) else $error("hang started");
   property p_go;
      go && !busy && !soft_reset_bit && !disable_cmd ##1 !soft_reset_bit
         |=> busy;
   endproperty
   a_go: assert property (p_go) else $error("no start");
   c_go: cover property (go && !busy);
   c_hang: cover property (master_mode && hang && tx_write);
   c_slv: cover property (slv && disable_cmd);
endmodule
bind spi_quirk_core spi_quirk_checker #(.NS(NS)) u_chk (.*);
`default_nettype wire

// File: test/remote_slave.sv
`timescale 1ns/100ps
`default_nettype none
module remote_slave (
   input wire logic sck_out,
   input wire logic [3:0] select_out_n,
   input wire logic [7:0] word,
   output logic miso_in
);
   // Mode 0 only: sample on rising, shift on falling
   logic [7:0] sh;
   wire sel_n = &select_out_n;
   initial miso_in = 1'b0;
   always @(negedge sel_n) {miso_in, sh} = {word[7], word};
   always @(negedge sck_out) if (!sel_n) {miso_in, sh} = {sh[6], sh[6:0], 1'b0};
   // Released line inverts so a stale bit is never taken as data
   always @(posedge sel_n) miso_in = ~miso_in;
endmodule
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_top;
   logic sys_clk = 1'b0;
   logic reset_n, enable_cmd, disable_cmd, soft_reset_bit, master_mode;
   logic fault_detect_disable, tx_write, rx_read, sck_in, mosi_in, miso_in;
   logic select_in_n, fault_in_n, sck_out, sck_oe, mosi_out, mosi_oe;
   logic miso_out, miso_oe, spi_enabled, transmit_empty_flag, busy;
   logic receive_full_flag, mode_fault_flag;
   logic [1:0] select_index;
   logic [3:0] select_out_n;
   logic [7:0] tx_data, word, received_word_register;
   logic [63:0] select_config_register;
   integer seed, compares, miscompares, i, k;
   spi_quirk_core u_dut (.*);
   remote_slave u_peer (.*);
   initial forever #50 sys_clk = ~sys_clk;
   task pulse(input logic [2:0] m);
      @(negedge sys_clk) {soft_reset_bit, disable_cmd, enable_cmd} = m;
      @(negedge sys_clk) {soft_reset_bit, disable_cmd, enable_cmd} = 3'h0;
   endtask
   task send(input logic [7:0] d);
      @(negedge sys_clk) {tx_write, tx_data} = {1'b1, d};
      @(negedge sys_clk) tx_write = 1'b0;
   endtask
   task settle;
      repeat (2) @(negedge sys_clk);
      for (i = 0; i < 4000 && busy !== 1'b0; i++) @(negedge sys_clk);
   endtask
   function logic hangs(input logic [63:0] c, input logic f);
      return c[2] && !f;
   endfunction
   task conclude;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #3000000 miscompares++;
      conclude;
   end
   initial begin
      {reset_n, enable_cmd, disable_cmd, soft_reset_bit, tx_write} = 5'h00;
      {rx_read, sck_in, mosi_in, select_in_n, fault_in_n} = 5'h03;
      {master_mode, fault_detect_disable, select_index} = 4'hC;
      {tx_data, word, select_config_register} = {16'h0000, {4{16'h0202}}};
      {seed, compares, miscompares} = {32'h185320BE, 64'h0};
      repeat (20) @(posedge sys_clk);
      @(negedge sys_clk) reset_n = 1'b1;
      @(negedge sys_clk);
      `CHK("sel", 4'hF, select_out_n)
      `CHK("empty", 1'b1, transmit_empty_flag)
      pulse(3'h1);
      // Each select gets its own divider; the checks see only the received word and full flag
      for (k = 0; k < 4; k++) begin
         select_index = k[1:0];
         select_config_register[16*k+10 +: 2] = 2'($random(seed));
         word = 8'($random(seed));
         send(8'($random(seed)));
         settle;
         `CHK("rx", word, received_word_register)
         `CHK("full", 1'b1, receive_full_flag)
      end
      pulse(3'h2);
      repeat (3) send(8'($random(seed)));
      `CHK("empty", 1'b1, transmit_empty_flag)
      pulse(3'h1);
      @(negedge sys_clk);
      `CHK("busy", 1'b0, busy)
      {select_index, fault_detect_disable} = 3'h0;
      select_config_register[2] = 1'b1;
      send(8'hA5);
      repeat (4) @(negedge sys_clk);
      `CHK("busy", !hangs(select_config_register, 1'b0), busy)
      pulse(3'h4);
      pulse(3'h1);
      {fault_detect_disable, word} = 9'h13C;
      send(8'hC3);
      @(negedge sys_clk);
      `CHK("busy", !hangs(select_config_register, 1'b1), busy)
      settle;
      `CHK("rx", 8'h3C, received_word_register)
      master_mode = 1'b0;
      pulse(3'h1);
      pulse(3'h2);
      `CHK("on", 1'b1, spi_enabled)
      pulse(3'h4);
      `CHK("on", 1'b0, spi_enabled)
      pulse(3'h1);
      @(negedge sys_clk) select_in_n = 1'b0;
      @(negedge sys_clk) select_in_n = 1'b1;
      `CHK("glitch", 1'b1, receive_full_flag)
      select_config_register[0] = 1'b1;
      @(negedge sys_clk) select_config_register[0] = 1'b0;
      @(negedge sys_clk) rx_read = 1'b1;
      @(negedge sys_clk) rx_read = 1'b0;
      `CHK("glitch", 1'b0, receive_full_flag)
      {master_mode, fault_detect_disable} = 2'b10;
      pulse(3'h1);
      @(negedge sys_clk) fault_in_n = 1'b0;
      @(negedge sys_clk) fault_in_n = 1'b1;
      `CHK("fault", 1'b1, mode_fault_flag)
      conclude;
   end
endmodule
`default_nettype wire
